// ---- sysc_defines.svh ----
`ifndef SYSC_DEFINES_SVH
`define SYSC_DEFINES_SVH

// ----------------------------------------
// Bus geometry and answers
// ----------------------------------------
`define SYSC_ADDR_W 8
`define SYSC_DATA_W 32
`define SYSC_STRB_W 4
`define SYSC_RESP_OKAY 2'h0
`define SYSC_RESP_SLVERR 2'h2
`define SYSC_PAD_W 24

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SYSC_OFS_OPTIONS 8'h00
`define SYSC_OFS_CLKOUT 8'h04
`define SYSC_OFS_PART_HI 8'h08
`define SYSC_OFS_PART_LO 8'h0C
`define SYSC_OFS_WAKEUP 8'h10
`define SYSC_OFS_WORD 7:2

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SYSC_OPT_WDOG_EN 7
`define SYSC_OPT_WDOG_LONG 6
`define SYSC_OPT_STOP_PERMIT 5
`define SYSC_CKO_EN 4
`define SYSC_CKO_DIV 2:0
`define SYSC_WK_FLAG 7
`define SYSC_WK_ACK 6
`define SYSC_WK_CLKSEL 5
`define SYSC_WK_IE 4
`define SYSC_WK_DLY 2:0
`define SYSC_PID_HI_FIELD 3:0
`define SYSC_PID_UPPER 11:8
`define SYSC_PID_LOWER 7:0

// ----------------------------------------
// Reset values and identity
// ----------------------------------------
`define SYSC_RST_WDOG_EN 1'h1
`define SYSC_RST_WDOG_LONG 1'h1
`define SYSC_RST_STOP_PERMIT 1'h0
`define SYSC_PART_NUMBER 12'hA5C

// ----------------------------------------
// Timing
// ----------------------------------------
`define SYSC_CLK_PERIOD_NS 10
`define SYSC_OSC_PERIOD_US 1000
`define SYSC_OSC_DIV ((`SYSC_OSC_PERIOD_US * 1000) / `SYSC_CLK_PERIOD_NS)
`define SYSC_OSC_CNT_W 17
`define SYSC_WK_CNT_W 16
`define SYSC_CKO_CNT_W 3

// Wakeup periods in ticks, internal 1 kHz source (1 tick = 1 ms)
`define SYSC_INT_TICKS_1 16'h0008
`define SYSC_INT_TICKS_2 16'h0020
`define SYSC_INT_TICKS_3 16'h0040
`define SYSC_INT_TICKS_4 16'h0080
`define SYSC_INT_TICKS_5 16'h0100
`define SYSC_INT_TICKS_6 16'h0200
`define SYSC_INT_TICKS_7 16'h0400
// Wakeup periods in external clock edges
`define SYSC_EXT_TICKS_1 16'h0100
`define SYSC_EXT_TICKS_2 16'h0400
`define SYSC_EXT_TICKS_3 16'h0800
`define SYSC_EXT_TICKS_4 16'h1000
`define SYSC_EXT_TICKS_5 16'h2000
`define SYSC_EXT_TICKS_6 16'h4000
`define SYSC_EXT_TICKS_7 16'h8000

`endif

// ---- sysc_pkg.sv ----
`default_nettype none
package sysc_pkg;
  `include "sysc_defines.svh"

  typedef enum logic {WR_COLLECT, WR_RESP} sysc_wr_e;

  typedef struct packed {
    logic awvalid;
    logic [`SYSC_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [`SYSC_DATA_W-1:0] wdata;
    logic [`SYSC_STRB_W-1:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`SYSC_ADDR_W-1:0] araddr;
    logic rready;
  } sysc_axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [`SYSC_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } sysc_axil_rsp_s;

  typedef struct packed {
    logic watchdogEnable;
    logic watchdogLongTimeout;
    logic stopPermit;
    logic illegalOpcodeReset;
    logic stopEnter;
    logic clockOutPin;
    logic clockOutEnableN;
    logic wakeupIrq;
  } sysc_sys_out_s;
endpackage
`default_nettype wire

// ---- sysc_config.sv ----
// Overview of operation
// - Options register takes only its first write after reset; reads always allowed.
// - Options bits 3 and 2 read as zero.
// - Watchdog enable resets to one; one enables watchdog reset on timeout.
// - Watchdog long-timeout bit resets to one; zero short, one long.
// - Stop permit resets to zero; one allows stop mode.
// - Stop attempt while stop not permitted forces an illegal opcode reset.
// - Clock output enable drives divided clock onto its pin.
// - Nonzero divide field gives bus clock over twice the field value.
// - Divide field zero with output enabled holds pin low.
// - Part number registers show a fixed 12-bit part number, split high/low.
// - Upper nibble of part number high is reserved; writes have no effect.
// - Wakeup flag is read-only and set on each wakeup timer timeout.
// - Acknowledge bit: write one clears flag, zero ignored, reads zero.
// - Clock select zero picks internal 1 kHz source, one the external clock.
// - Wakeup interrupt enable gates the wakeup interrupt request.
// - Delay select zero stops the wakeup timer.
// - Internal source delays are 8, 32, 64, 128, 256, 512 ms and 1.024 s.
// - External source delays divide by 256 up to 32768 in order.
// - Unimplemented wakeup control bits read as zero.
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sysc_defines.svh"

module sysc_config #(
  parameter int OSC_DIV = `SYSC_OSC_DIV,
  parameter logic [11:0] PART_NUMBER = `SYSC_PART_NUMBER
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register bus
  input wire sysc_pkg::sysc_axil_req_s axiReq,
  output var sysc_pkg::sysc_axil_rsp_s axiRsp,
  // Processor and pins
  input wire logic stopAttempt,
  input wire logic extClkPin,
  // System controls
  output var sysc_pkg::sysc_sys_out_s sysOut
);
  import sysc_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    sysc_axil_rsp_s rsp;
    sysc_wr_e wrState;
    logic awHeld;
    logic wHeld;
    logic [`SYSC_ADDR_W-1:0] awAddr;
    logic [`SYSC_DATA_W-1:0] wData;
    logic [`SYSC_STRB_W-1:0] wStrb;
    logic optWritten;
    logic wdogEn;
    logic wdogLong;
    logic stopPermit;
    logic illegalOp;
    logic stopEnter;
    logic ckoEn;
    logic [`SYSC_CKO_CNT_W-1:0] ckoDiv;
    logic [`SYSC_CKO_CNT_W-1:0] ckoCnt;
    logic ckoPin;
    logic ckoEnN;
    logic wkFlag;
    logic wkClkSel;
    logic wkIe;
    logic [2:0] wkDly;
    logic [`SYSC_WK_CNT_W-1:0] wkCnt;
    logic [`SYSC_OSC_CNT_W-1:0] oscCnt;
    logic extS1;
    logic extS2;
    logic extS3;
    logic extLvl;
    logic wkIrq;
  } sysc_state_s;

  localparam logic [`SYSC_OSC_CNT_W-1:0] OSC_LAST = `SYSC_OSC_CNT_W'(OSC_DIV - 1);

  sysc_state_s q;
  sysc_state_s d;
  logic doWrite;
  logic wrEn;
  logic [7:0] wrByte;
  logic oscTick;
  logic extTick;
  logic wkTick;
  logic wkSet;
  logic wkAck;
  logic wkRestart;
  logic [`SYSC_WK_CNT_W-1:0] wkLast;

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic ofsHit(input logic [`SYSC_ADDR_W-1:0] a,
                                  input logic [`SYSC_ADDR_W-1:0] ofs);
    ofsHit = (a[`SYSC_OFS_WORD] == ofs[`SYSC_OFS_WORD]);
  endfunction

  function automatic logic isMapped(input logic [`SYSC_ADDR_W-1:0] a);
    isMapped = ofsHit(a, `SYSC_OFS_OPTIONS) || ofsHit(a, `SYSC_OFS_CLKOUT) ||
               ofsHit(a, `SYSC_OFS_PART_HI) || ofsHit(a, `SYSC_OFS_PART_LO) ||
               ofsHit(a, `SYSC_OFS_WAKEUP);
  endfunction

  // Write strobe aimed at one register word
  function automatic logic wrHit(input logic en,
                                 input logic [`SYSC_ADDR_W-1:0] a,
                                 input logic [`SYSC_ADDR_W-1:0] ofs);
    wrHit = en && ofsHit(a, ofs);
  endfunction

  // Period of the wakeup timer in source ticks
  function automatic logic [`SYSC_WK_CNT_W-1:0] tickLimit(input logic ext,
                                                          input logic [2:0] code);
    logic [`SYSC_WK_CNT_W-1:0] lim;
    lim = `SYSC_INT_TICKS_1;
    case (code)
      3'h1: lim = ext ? `SYSC_EXT_TICKS_1 : `SYSC_INT_TICKS_1;
      3'h2: lim = ext ? `SYSC_EXT_TICKS_2 : `SYSC_INT_TICKS_2;
      3'h3: lim = ext ? `SYSC_EXT_TICKS_3 : `SYSC_INT_TICKS_3;
      3'h4: lim = ext ? `SYSC_EXT_TICKS_4 : `SYSC_INT_TICKS_4;
      3'h5: lim = ext ? `SYSC_EXT_TICKS_5 : `SYSC_INT_TICKS_5;
      3'h6: lim = ext ? `SYSC_EXT_TICKS_6 : `SYSC_INT_TICKS_6;
      3'h7: lim = ext ? `SYSC_EXT_TICKS_7 : `SYSC_INT_TICKS_7;
      default: lim = `SYSC_INT_TICKS_1;
    endcase
    tickLimit = lim;
  endfunction

  // Read view; unlisted bits stay zero
  function automatic logic [7:0] readByte(input sysc_state_s s,
                                          input logic [`SYSC_ADDR_W-1:0] a);
    logic [7:0] b;
    b = 8'h00;
    if (ofsHit(a, `SYSC_OFS_OPTIONS)) begin
      b[`SYSC_OPT_WDOG_EN] = s.wdogEn;
      b[`SYSC_OPT_WDOG_LONG] = s.wdogLong;
      b[`SYSC_OPT_STOP_PERMIT] = s.stopPermit;
    end else if (ofsHit(a, `SYSC_OFS_CLKOUT)) begin
      b[`SYSC_CKO_EN] = s.ckoEn;
      b[`SYSC_CKO_DIV] = s.ckoDiv;
    end else if (ofsHit(a, `SYSC_OFS_PART_HI)) begin
      b[`SYSC_PID_HI_FIELD] = PART_NUMBER[`SYSC_PID_UPPER];
    end else if (ofsHit(a, `SYSC_OFS_PART_LO)) begin
      b = PART_NUMBER[`SYSC_PID_LOWER];
    end else if (ofsHit(a, `SYSC_OFS_WAKEUP)) begin
      b[`SYSC_WK_FLAG] = s.wkFlag;
      b[`SYSC_WK_CLKSEL] = s.wkClkSel;
      b[`SYSC_WK_IE] = s.wkIe;
      b[`SYSC_WK_DLY] = s.wkDly;
    end
    readByte = b;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d = q;
    doWrite = 1'b0;
    wkSet = 1'b0;
    wkAck = 1'b0;
    wkRestart = 1'b0;
    oscTick = 1'b0;
    extTick = 1'b0;
    d.illegalOp = 1'b0;
    d.stopEnter = 1'b0;

    // ----------------------------------------
    // Write channel: address and data in either order
    // ----------------------------------------
    case (q.wrState)
      WR_COLLECT: begin
        if (axiReq.awvalid && q.rsp.awready) begin
          d.awAddr = axiReq.awaddr;
          d.awHeld = 1'b1;
          d.rsp.awready = 1'b0;
        end
        if (axiReq.wvalid && q.rsp.wready) begin
          d.wData = axiReq.wdata;
          d.wStrb = axiReq.wstrb;
          d.wHeld = 1'b1;
          d.rsp.wready = 1'b0;
        end
        if (q.awHeld && q.wHeld) begin
          doWrite = 1'b1;
          d.awHeld = 1'b0;
          d.wHeld = 1'b0;
          d.rsp.bvalid = 1'b1;
          d.rsp.bresp = isMapped(q.awAddr) ? `SYSC_RESP_OKAY : `SYSC_RESP_SLVERR;
          d.wrState = WR_RESP;
        end
      end
      WR_RESP: begin
        if (axiReq.bready) begin
          d.rsp.bvalid = 1'b0;
          d.rsp.awready = 1'b1;
          d.rsp.wready = 1'b1;
          d.wrState = WR_COLLECT;
        end
      end
      default: begin
        d.wrState = WR_COLLECT;
      end
    endcase

    // ----------------------------------------
    // Read channel: one read in flight
    // ----------------------------------------
    if (!q.rsp.rvalid) begin
      if (axiReq.arvalid && q.rsp.arready) begin
        d.rsp.arready = 1'b0;
        d.rsp.rvalid = 1'b1;
        d.rsp.rdata = {`SYSC_PAD_W'h000000, readByte(q, axiReq.araddr)};
        d.rsp.rresp = isMapped(axiReq.araddr) ? `SYSC_RESP_OKAY : `SYSC_RESP_SLVERR;
      end
    end else if (axiReq.rready) begin
      d.rsp.rvalid = 1'b0;
      d.rsp.arready = 1'b1;
    end

    // ----------------------------------------
    // All registers live in byte lane 0
    // ----------------------------------------
    wrEn = doWrite && q.wStrb[0];
    wrByte = q.wData[7:0];

    // ----------------------------------------
    // Options: first write locks the register until reset
    // ----------------------------------------
    if (wrHit(wrEn, q.awAddr, `SYSC_OFS_OPTIONS) && !q.optWritten) begin
      d.optWritten = 1'b1;
      d.wdogEn = wrByte[`SYSC_OPT_WDOG_EN];
      d.wdogLong = wrByte[`SYSC_OPT_WDOG_LONG];
      d.stopPermit = wrByte[`SYSC_OPT_STOP_PERMIT];
    end

    // ----------------------------------------
    // Stop request resolves to entry or illegal opcode reset
    // ----------------------------------------
    if (stopAttempt) begin
      if (q.stopPermit) begin
        d.stopEnter = 1'b1;
      end else begin
        d.illegalOp = 1'b1;
      end
    end

    // ----------------------------------------
    // Clock output control; part number writes fall through untouched
    // ----------------------------------------
    if (wrHit(wrEn, q.awAddr, `SYSC_OFS_CLKOUT)) begin
      d.ckoEn = wrByte[`SYSC_CKO_EN];
      d.ckoDiv = wrByte[`SYSC_CKO_DIV];
      d.ckoCnt = '0;
    end

    // ----------------------------------------
    // Divided clock: toggle every N bus cycles, period 2N
    // ----------------------------------------
    d.ckoEnN = !q.ckoEn;
    if (!q.ckoEn || (q.ckoDiv == '0)) begin
      d.ckoPin = 1'b0;
      d.ckoCnt = '0;
    end else if (wrHit(wrEn, q.awAddr, `SYSC_OFS_CLKOUT)) begin
      d.ckoPin = 1'b0;
    end else if (q.ckoCnt == `SYSC_CKO_CNT_W'(q.ckoDiv - 3'h1)) begin
      d.ckoCnt = '0;
      d.ckoPin = !q.ckoPin;
    end else begin
      d.ckoCnt = `SYSC_CKO_CNT_W'(q.ckoCnt + 3'h1);
    end

    // ----------------------------------------
    // Wakeup control writes
    // ----------------------------------------
    if (wrHit(wrEn, q.awAddr, `SYSC_OFS_WAKEUP)) begin
      wkAck = wrByte[`SYSC_WK_ACK];
      d.wkClkSel = wrByte[`SYSC_WK_CLKSEL];
      d.wkIe = wrByte[`SYSC_WK_IE];
      d.wkDly = wrByte[`SYSC_WK_DLY];
      // A new period or source starts a fresh count
      wkRestart = (wrByte[`SYSC_WK_CLKSEL] != q.wkClkSel) ||
                  (wrByte[`SYSC_WK_DLY] != q.wkDly);
    end

    // ----------------------------------------
    // External clock: a level counts once stages two and three agree
    // ----------------------------------------
    d.extS1 = extClkPin;
    d.extS2 = q.extS1;
    d.extS3 = q.extS2;
    if (q.extS2 == q.extS3) begin
      d.extLvl = q.extS3;
      extTick = q.extS3 && !q.extLvl;
    end

    // ----------------------------------------
    // Internal 1 kHz source derived from the bus clock
    // ----------------------------------------
    if (q.oscCnt == OSC_LAST) begin
      d.oscCnt = '0;
      oscTick = 1'b1;
    end else begin
      d.oscCnt = `SYSC_OSC_CNT_W'(q.oscCnt + 17'h00001);
    end

    wkTick = q.wkClkSel ? extTick : oscTick;
    wkLast = `SYSC_WK_CNT_W'(tickLimit(q.wkClkSel, q.wkDly) - 16'h0001);

    if (q.wkDly == 3'h0) begin
      d.wkCnt = '0;
    end else if (wkRestart) begin
      d.wkCnt = '0;
    end else if (wkTick) begin
      if (q.wkCnt == wkLast) begin
        d.wkCnt = '0;
        wkSet = 1'b1;
      end else begin
        d.wkCnt = `SYSC_WK_CNT_W'(q.wkCnt + 16'h0001);
      end
    end

    // ----------------------------------------
    // Timeout beats acknowledge in the same cycle
    // ----------------------------------------
    if (wkSet) begin
      d.wkFlag = 1'b1;
    end else if (wkAck) begin
      d.wkFlag = 1'b0;
    end
    d.wkIrq = d.wkFlag && d.wkIe;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.wrState <= WR_COLLECT;
      q.rsp.awready <= 1'b1;
      q.rsp.wready <= 1'b1;
      q.rsp.arready <= 1'b1;
      q.wdogEn <= `SYSC_RST_WDOG_EN;
      q.wdogLong <= `SYSC_RST_WDOG_LONG;
      q.stopPermit <= `SYSC_RST_STOP_PERMIT;
      q.ckoEnN <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign axiRsp = q.rsp;
  assign sysOut.watchdogEnable = q.wdogEn;
  assign sysOut.watchdogLongTimeout = q.wdogLong;
  assign sysOut.stopPermit = q.stopPermit;
  assign sysOut.illegalOpcodeReset = q.illegalOp;
  assign sysOut.stopEnter = q.stopEnter;
  assign sysOut.clockOutPin = q.ckoPin;
  assign sysOut.clockOutEnableN = q.ckoEnN;
  assign sysOut.wakeupIrq = q.wkIrq;
endmodule
`default_nettype wire

// ---- sysc_config_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module sysc_config_monitor #(
  parameter int OSC_DIV = 4,
  parameter logic [11:0] PART_NUMBER = 12'h000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register bus
  input wire sysc_pkg::sysc_axil_req_s axiReq,
  input wire sysc_pkg::sysc_axil_rsp_s axiRsp,
  // Pins and controls
  input wire logic stopAttempt,
  input wire logic extClkPin,
  input wire sysc_pkg::sysc_sys_out_s sysOut
);
  import sysc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----
  // Helpers
  // ----
  logic wTake;
  logic [7:0] arQ;
  logic lockQ;
  assign wTake = axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
  // Word address of the read in flight
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arQ <= 8'h00;
      lockQ <= 1'b0;
    end else begin
      if (axiReq.arvalid && axiRsp.arready)
        arQ <= axiReq.araddr;
      if (wTake && axiReq.awaddr[7:2] == 6'h00 && axiReq.wstrb[0])
        lockQ <= 1'b1;
    end
  end
  // ----
  // Properties
  // ----
  a_wr_answer: assert property (wTake |=> !axiRsp.bvalid ##1 axiRsp.bvalid)
    else $error("write answer late");
  a_rd_answer: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
    else $error("read answer late");
  a_rd_hold: assert property (axiRsp.rvalid && !axiReq.rready
    |=> axiRsp.rvalid && $stable(axiRsp.rdata))
    else $error("read data dropped");
  a_opt_lock: assert property (lockQ && $past(lockQ, 3) |-> $stable({sysOut.watchdogEnable,
    sysOut.watchdogLongTimeout, sysOut.stopPermit}))
    else $error("options changed after lock");
  a_opt_zero: assert property (axiRsp.rvalid && arQ[7:2] == 6'h00
    |-> axiRsp.rdata[3:2] == 2'h0)
    else $error("options spare bits set");
  a_part_high: assert property (axiRsp.rvalid && arQ[7:2] == 6'h02
    |-> axiRsp.rdata[3:0] == PART_NUMBER[11:8])
    else $error("part high wrong");
  a_part_low: assert property (axiRsp.rvalid && arQ[7:2] == 6'h03
    |-> axiRsp.rdata[7:0] == PART_NUMBER[7:0])
    else $error("part low wrong");
  a_wake_zero: assert property (axiRsp.rvalid && arQ[7:2] == 6'h04
    |-> !axiRsp.rdata[6] && !axiRsp.rdata[3])
    else $error("wakeup spare bits set");
  a_stop_trap: assert property (stopAttempt && !sysOut.stopPermit
    |=> sysOut.illegalOpcodeReset && !sysOut.stopEnter)
    else $error("stop not trapped");
  a_stop_ok: assert property (stopAttempt && sysOut.stopPermit |=> sysOut.stopEnter)
    else $error("stop not entered");
  a_pin_idle: assert property (sysOut.clockOutEnableN [*2] |-> !sysOut.clockOutPin)
    else $error("pin active while off");
endmodule
bind sysc_config sysc_config_monitor #(.OSC_DIV(OSC_DIV), .PART_NUMBER(PART_NUMBER))
  i_sysc_config_monitor (.clk(clk), .rst(rst), .ce(ce), .axiReq(axiReq), .axiRsp(axiRsp),
  .stopAttempt(stopAttempt), .extClkPin(extClkPin), .sysOut(sysOut));
`default_nettype wire

// ---- sysc_config_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module sysc_config_tb_top;
  import sysc_pkg::*;
  localparam int OSC = 4;
  // Arbitrary part number
  localparam logic [11:0] PN = 12'h3B7;
  localparam logic [33:0] ALL = 34'h3FFFFFFFF;
  localparam int TK [1:7] = '{8, 32, 64, 128, 256, 512, 1024};
  localparam int EX [1:3] = '{256, 1024, 2048};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic stopAttempt = 1'b0;
  logic extClkPin = 1'b0;
  logic [2:0] extCnt = 3'h0;
  sysc_axil_req_s rq = '0;
  sysc_axil_rsp_s rs;
  sysc_sys_out_s so;
  logic [33:0] expQ[$];
  logic [33:0] mskQ[$];
  int nErrors = 0;
  int testsRun = 0;
  int cyc = 0;
  int t;
  int p;
  logic cs;
  logic [2:0] dl;
  logic [31:0] r;

  sysc_config #(.OSC_DIV(OSC), .PART_NUMBER(PN)) i_sysc_config (.clk(clk), .rst(rst),
    .ce(ce), .axiReq(rq), .axiRsp(rs), .stopAttempt(stopAttempt),
    .extClkPin(extClkPin), .sysOut(so));

  always #5 clk = ~clk;
  // External wakeup clock: eight bus cycles a period
  always @(posedge clk) begin
    extCnt <= extCnt + 3'h1;
    extClkPin <= extCnt[2];
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      nErrors++;
      finishTest();
    end
  end

  task automatic finishTest();
    if (nErrors == 0 && testsRun > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    testsRun++;
    if (g !== e) begin
      nErrors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask

  // ----
  // Bus tasks
  // ----
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    rq.awaddr <= a;
    rq.wdata <= d;
    rq.wstrb <= 4'hF;
    do @(posedge clk); while (!(rs.awready && rs.wready));
    rq.awvalid <= 1'b0;
    rq.wvalid <= 1'b0;
    do @(posedge clk); while (!rs.bvalid);
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m);
    expQ.push_back(e & m);
    mskQ.push_back(m);
    rq.arvalid <= 1'b1;
    rq.araddr <= a;
    do @(posedge clk); while (!rs.arready);
    rq.arvalid <= 1'b0;
    do @(posedge clk); while (!rs.rvalid);
  endtask

  // Read results against the oldest note
  always @(posedge clk) begin
    if (rs.rvalid && rq.rready) begin
      chk({rs.rresp, rs.rdata} & mskQ.pop_front(), expQ.pop_front());
    end
  end

  task automatic pulseStop();
    stopAttempt <= 1'b1;
    @(posedge clk);
    stopAttempt <= 1'b0;
    @(posedge clk);
  endtask

  task automatic resetFor16();
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  // ----
  // Scenarios
  // ----
  initial begin
    void'($urandom(32'h10154EB2));
    // Answer channels stay ready, so back-to-back calls never retoggle them
    rq.bready <= 1'b1;
    rq.rready <= 1'b1;
    resetFor16();
    rd(8'h00, 34'h0C0, ALL);
    chk(34'({so.watchdogEnable, so.watchdogLongTimeout, so.stopPermit}), 34'h6);
    pulseStop();
    r = $urandom | 32'h2C;
    wr(8'h00, r);
    rd(8'h00, {26'h0, r[7:5], 5'h0}, ALL);
    chk(34'({so.watchdogEnable, so.watchdogLongTimeout, so.stopPermit}), 34'(r[7:5]));
    wr(8'h00, ~r);
    rd(8'h00, {26'h0, r[7:5], 5'h0}, ALL);
    pulseStop();
    resetFor16();
    wr(8'h00, 32'hC0);
    wr(8'h00, 32'h20);
    rd(8'h00, 34'h0C0, ALL);
    pulseStop();
    wr(8'h08, $urandom);
    rd(8'h08, {30'h0, PN[11:8]}, 34'h00F);
    rd(8'h0C, {26'h0, PN[7:0]}, ALL);
    // Unmapped word answers with an error
    rd(8'h20, 34'h200000000, ALL);
    for (int d = 1; d < 8; d++) begin
      wr(8'h04, {27'h0, 2'h2, 3'(d)});
      rd(8'h04, {29'h0, 2'h2, 3'(d)}, ALL);
      while (so.clockOutPin) @(posedge clk);
      while (!so.clockOutPin) @(posedge clk);
      t = 0;
      while (so.clockOutPin) begin
        @(posedge clk);
        t++;
      end
      chk(34'(t), 34'(d));
      chk(34'(so.clockOutEnableN), 34'h0);
    end
    // Clock enable low freezes the divided clock
    ce <= 1'b0;
    @(posedge clk);
    cs = so.clockOutPin;
    repeat (20) begin
      @(posedge clk);
      chk(34'(so.clockOutPin), 34'(cs));
    end
    ce <= 1'b1;
    wr(8'h04, 32'h10);
    repeat (8) begin
      @(posedge clk);
      chk(34'(so.clockOutPin), 34'h0);
    end
    wr(8'h04, 32'h07);
    repeat (2) @(posedge clk);
    chk(34'({so.clockOutEnableN, so.clockOutPin}), 34'h2);
    wr(8'h10, 32'hFF);
    rd(8'h10, 34'h037, ALL);
    wr(8'h10, 32'h40);
    wr(8'h10, 32'h01);
    repeat (60) @(posedge clk);
    chk(34'(so.wakeupIrq), 34'h0);
    rd(8'h10, 34'h081, ALL);
    wr(8'h10, 32'h11);
    repeat (2) @(posedge clk);
    chk(34'(so.wakeupIrq), 34'h1);
    // Stop the timer first so no timeout can meet the acknowledge
    wr(8'h10, 32'h10);
    wr(8'h10, 32'h50);
    repeat (60) @(posedge clk);
    chk(34'(so.wakeupIrq), 34'h0);
    rd(8'h10, 34'h010, ALL);
    // Internal codes 1..7, then external codes 1..3
    for (int c = 1; c < 11; c++) begin
      cs = c > 7;
      dl = 3'(cs ? c - 7 : c);
      p = cs ? EX[dl] * 8 : TK[dl] * OSC;
      wr(8'h10, {26'h0, cs, 1'b1, 1'b0, dl});
      t = 0;
      while (!so.wakeupIrq) begin
        @(posedge clk);
        t++;
      end
      chk(34'(t > p - 16 && t < p + 16), 34'h1);
      rd(8'h10, {26'h0, 1'b1, 1'b0, cs, 1'b1, 1'b0, dl}, ALL);
      wr(8'h10, 32'h40);
    end
    finishTest();
  end
endmodule
`default_nettype wire
